// file: common/trim_pkg.sv
// Functional notes
// - Identity register returns fixed variant code, read-only
// - Host reads identity before any configuration
// - Unexpected identity value means failed communication
// - Host opens guard before writing trim registers
// - Host closes guard after trim writes finish
// - Apply register: bit 0 only, others zero
// - Apply bit gates both stored trim codes
// - Host loads both codes, then sets apply
// - Bandgap correction code, 8-bit, resets zero
// - Buffer amplifier code, 8-bit, resets zero
package trim_pkg;

  // ==========================================================
  // Device register map
  localparam logic [7:0] ADDR_IDENTITY   = 8'h5e;
  localparam logic [7:0] ADDR_GUARD      = 8'h60;
  localparam logic [7:0] ADDR_APPLY      = 8'h74;
  localparam logic [7:0] ADDR_BANDGAP    = 8'h78;
  localparam logic [7:0] ADDR_BUFFER     = 8'h7a;

  localparam logic [7:0] RESET_GUARD     = 8'h00;
  localparam logic [7:0] RESET_APPLY     = 8'h00;
  localparam logic [7:0] RESET_BANDGAP   = 8'h00;
  localparam logic [7:0] RESET_BUFFER    = 8'h00;

  // Guard value that opens the trim registers; any other value protects
  localparam logic [7:0] GUARD_OPEN_KEY  = 8'h01;
  localparam logic [7:0] GUARD_CLOSE_KEY = 8'h00;
  localparam int         APPLY_BIT       = 0;

  // ==========================================================
  // Controller register map (AXI4-Lite byte addresses)
  localparam logic [7:0] CSR_CTRL        = 8'h00;
  localparam logic [7:0] CSR_CODES       = 8'h04;
  localparam logic [7:0] CSR_STATUS      = 8'h08;

  localparam int         CTRL_CHECK_BIT  = 0;
  localparam int         CTRL_TRIM_BIT   = 1;
  localparam int         ST_BUSY_BIT     = 0;
  localparam int         ST_ID_OK_BIT    = 1;
  localparam int         ST_FAIL_BIT     = 2;
  localparam int         ST_DONE_BIT     = 3;
  localparam int         ST_REFUSED_BIT  = 4;
  localparam int         ST_ID_LSB       = 8;

  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

endpackage

// file: common/trim_link_if.sv
`timescale 1ns/100ps
// Register access link between controller and device.
// A request is a one-cycle pulse; ack answers it on the next cycle.
interface trim_link_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output rdata,
    output ack
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input  rdata,
    input  ack
  );
endinterface

// file: logic/trim_reg_bank.sv
`timescale 1ns/100ps
// Identity, write guard and trim registers of the pre-driver.
module trim_reg_bank #(
  // Variant code; value is arbitrary
  parameter logic [7:0] ID_CODE = 8'h3c
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Register link
  trim_link_if.dev        link,
  // Trim codes toward the regulator
  output logic [7:0]      bandgap_trim_out,
  output logic [7:0]      buffer_trim_out,
  // Status
  output logic            trim_active,
  output logic            guard_open,
  output logic            write_refused
);

  // ==========================================================
  // Address decode
  function automatic logic is_protected(input logic [7:0] a);
    is_protected = (a == trim_pkg::ADDR_APPLY) ||
                   (a == trim_pkg::ADDR_BANDGAP) ||
                   (a == trim_pkg::ADDR_BUFFER);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_protected(a) ||
                (a == trim_pkg::ADDR_IDENTITY) ||
                (a == trim_pkg::ADDR_GUARD);
  endfunction

  logic [7:0] guard_reg;
  logic       apply_reg;
  logic [7:0] bandgap_reg;
  logic [7:0] buffer_reg;
  logic [7:0] rdata_reg;
  logic       ack_reg;
  logic       refused_reg;
  logic [7:0] bandgap_out_reg;
  logic [7:0] buffer_out_reg;
  logic       guard_unlocked;
  logic       wr_cycle;
  logic       wr_allowed;
  logic [7:0] rd_next;

  assign wr_cycle       = link.req && link.we;
  assign guard_unlocked = (guard_reg == trim_pkg::GUARD_OPEN_KEY);
  // Protected targets need the guard open; others are free to write
  assign wr_allowed     = wr_cycle &&
                          (!is_protected(link.addr) || guard_unlocked);

  // ==========================================================
  // Write guard
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_reg <= trim_pkg::RESET_GUARD;
    end else if (wr_cycle && link.addr == trim_pkg::ADDR_GUARD) begin
      guard_reg <= link.wdata;
    end
  end

  // ==========================================================
  // Apply register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      apply_reg <= trim_pkg::RESET_APPLY[trim_pkg::APPLY_BIT];
    end else if (wr_allowed && link.addr == trim_pkg::ADDR_APPLY) begin
      apply_reg <= link.wdata[trim_pkg::APPLY_BIT];
    end
  end

  // ==========================================================
  // Bandgap correction code
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_reg <= trim_pkg::RESET_BANDGAP;
    end else if (wr_allowed && link.addr == trim_pkg::ADDR_BANDGAP) begin
      bandgap_reg <= link.wdata;
    end
  end

  // ==========================================================
  // Buffer amplifier code
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_reg <= trim_pkg::RESET_BUFFER;
    end else if (wr_allowed && link.addr == trim_pkg::ADDR_BUFFER) begin
      buffer_reg <= link.wdata;
    end
  end

  // ==========================================================
  // Refused write indication
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= wr_cycle && is_protected(link.addr) && !guard_unlocked;
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    rd_next = 8'h00;
    case (link.addr)
      trim_pkg::ADDR_IDENTITY: rd_next = ID_CODE;
      trim_pkg::ADDR_GUARD:    rd_next = guard_reg;
      trim_pkg::ADDR_APPLY:    rd_next = {7'h00, apply_reg};
      trim_pkg::ADDR_BANDGAP:  rd_next = bandgap_reg;
      trim_pkg::ADDR_BUFFER:   rd_next = buffer_reg;
      default:                 rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (link.req && !link.we) begin
      // Unmapped reads return zero
      rdata_reg <= is_mapped(link.addr) ? rd_next : 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= link.req;
    end
  end

  // ==========================================================
  // Applied trim codes; default zero while apply is clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_out_reg <= 8'h00;
      buffer_out_reg  <= 8'h00;
    end else if (apply_reg) begin
      bandgap_out_reg <= bandgap_reg;
      buffer_out_reg  <= buffer_reg;
    end else begin
      bandgap_out_reg <= 8'h00;
      buffer_out_reg  <= 8'h00;
    end
  end

  // ==========================================================
  // Outputs
  assign link.rdata       = rdata_reg;
  assign link.ack         = ack_reg;
  assign bandgap_trim_out = bandgap_out_reg;
  assign buffer_trim_out  = buffer_out_reg;
  assign trim_active      = apply_reg;
  assign guard_open       = guard_unlocked;
  assign write_refused    = refused_reg;

endmodule

// file: logic/trim_host_ctrl.sv
`timescale 1ns/100ps
// Controller that checks the device identity and loads trim codes,
// commanded by software over AXI4-Lite.
module trim_host_ctrl #(
  // Identity code the controller accepts; value is arbitrary
  parameter logic [7:0] ID_EXPECTED = 8'h3c
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Device link
  trim_link_if.host        link,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  typedef enum logic [2:0] {
    S_IDLE, S_ID, S_OPEN, S_BG, S_BUF, S_APPLY, S_CLOSE
  } step_t;

  step_t       state_reg;
  logic        wait_reg;
  logic        req_reg;
  logic        we_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  bg_code_reg;
  logic [7:0]  buf_code_reg;
  logic        id_ok_reg;
  logic        fail_reg;
  logic        done_reg;
  logic        refused_reg;
  logic [7:0]  id_seen_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_fire;
  logic        go_check;
  logic        go_trim;
  logic [31:0] status_word;

  // Access issued in each step: {we, addr, wdata}
  function automatic logic [16:0] step_op(input step_t s, input logic [7:0] bg,
                                          input logic [7:0] bf);
    case (s)
      S_ID:    step_op = {1'b0, trim_pkg::ADDR_IDENTITY, 8'h00};
      S_OPEN:  step_op = {1'b1, trim_pkg::ADDR_GUARD, trim_pkg::GUARD_OPEN_KEY};
      S_BG:    step_op = {1'b1, trim_pkg::ADDR_BANDGAP, bg};
      S_BUF:   step_op = {1'b1, trim_pkg::ADDR_BUFFER, bf};
      S_APPLY: step_op = {1'b1, trim_pkg::ADDR_APPLY, 8'h01};
      S_CLOSE: step_op = {1'b1, trim_pkg::ADDR_GUARD, trim_pkg::GUARD_CLOSE_KEY};
      default: step_op = 17'h00000;
    endcase
  endfunction

  // ==========================================================
  // AXI4-Lite write channel
  assign awready = !aw_held_reg;
  assign wready  = !w_held_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= trim_pkg::RESP_OKAY;
    end else begin
      if (awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (aw_addr_reg == trim_pkg::CSR_CTRL ||
                        aw_addr_reg == trim_pkg::CSR_CODES) ?
                       trim_pkg::RESP_OKAY : trim_pkg::RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign go_check = wr_fire && aw_addr_reg == trim_pkg::CSR_CTRL && w_strb_reg[0] &&
                    w_data_reg[trim_pkg::CTRL_CHECK_BIT];
  assign go_trim  = wr_fire && aw_addr_reg == trim_pkg::CSR_CTRL && w_strb_reg[0] &&
                    w_data_reg[trim_pkg::CTRL_TRIM_BIT];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bg_code_reg  <= 8'h00;
      buf_code_reg <= 8'h00;
    end else if (wr_fire && aw_addr_reg == trim_pkg::CSR_CODES && state_reg == S_IDLE) begin
      if (w_strb_reg[0]) begin
        bg_code_reg <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        buf_code_reg <= w_data_reg[15:8];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign status_word = {16'h0000, id_seen_reg, 3'h0, refused_reg, done_reg,
                        fail_reg, id_ok_reg, (state_reg != S_IDLE)};
  assign arready = !rvalid_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= trim_pkg::RESP_OKAY;
    end else if (arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= trim_pkg::RESP_OKAY;
      case (araddr)
        trim_pkg::CSR_CTRL:   rdata_reg <= 32'h00000000;
        trim_pkg::CSR_CODES:  rdata_reg <= {16'h0000, buf_code_reg, bg_code_reg};
        trim_pkg::CSR_STATUS: rdata_reg <= status_word;
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= trim_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Sequencer: one link access per step, next step on ack
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg   <= 1'b0;
      wait_reg  <= 1'b0;
      we_reg    <= 1'b0;
      addr_reg  <= 8'h00;
      wdata_reg <= 8'h00;
    end else begin
      req_reg <= 1'b0;
      if (state_reg != S_IDLE && !wait_reg) begin
        req_reg <= 1'b1;
        wait_reg <= 1'b1;
        {we_reg, addr_reg, wdata_reg} <= step_op(state_reg, bg_code_reg, buf_code_reg);
      end else if (wait_reg && link.ack) begin
        wait_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (go_check) begin
            state_reg <= S_ID;
          end else if (go_trim && id_ok_reg) begin
            state_reg <= S_OPEN;
          end
        end
        default: begin
          if (wait_reg && link.ack) begin
            case (state_reg)
              S_ID:    state_reg <= S_IDLE;
              S_OPEN:  state_reg <= S_BG;
              S_BG:    state_reg <= S_BUF;
              S_BUF:   state_reg <= S_APPLY;
              S_APPLY: state_reg <= S_CLOSE;
              default: state_reg <= S_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_ok_reg   <= 1'b0;
      fail_reg    <= 1'b0;
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      id_seen_reg <= 8'h00;
    end else begin
      if (state_reg == S_ID && wait_reg && link.ack) begin
        id_seen_reg <= link.rdata;
        id_ok_reg   <= (link.rdata == ID_EXPECTED);
        fail_reg    <= (link.rdata != ID_EXPECTED);
      end
      if (state_reg == S_IDLE && go_trim) begin
        done_reg    <= 1'b0;
        refused_reg <= !id_ok_reg || go_check;
      end else if (state_reg == S_CLOSE && wait_reg && link.ack) begin
        done_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign link.req   = req_reg;
  assign link.we    = we_reg;
  assign link.addr  = addr_reg;
  assign link.wdata = wdata_reg;
  assign bvalid     = bvalid_reg;
  assign bresp      = bresp_reg;
  assign rvalid     = rvalid_reg;
  assign rdata      = rdata_reg;
  assign rresp      = rresp_reg;

endmodule

// file: bench/trim_link_asserts.sv
`timescale 1ns/100ps
module trim_link_asserts #(
  parameter logic [7:0] ID_CODE = 8'h3c
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Link
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack
);
  logic rd_id_reg;
  logic id_seen_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Identity read tracking
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rd_id_reg <= 1'b0;
    else rd_id_reg <= req && !we && (addr == trim_pkg::ADDR_IDENTITY);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) id_seen_reg <= 1'b0;
    else if (ack && rd_id_reg) id_seen_reg <= (rdata == ID_CODE);
  end

  // ==========================================================
  // Link properties
  a_ack_timing: assert property (req |=> ack ##1 !ack)
    else $error("ack not one cycle after req");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without req");
  a_id_value: assert property (
    req && !we && addr == trim_pkg::ADDR_IDENTITY |=> rdata == ID_CODE)
    else $error("identity read wrong");
  a_id_no_write: assert property (req |-> !(we && addr == trim_pkg::ADDR_IDENTITY))
    else $error("identity written");
  a_id_before_trim: assert property (
    req && we && addr == trim_pkg::ADDR_GUARD && wdata == trim_pkg::GUARD_OPEN_KEY
    |-> id_seen_reg)
    else $error("guard opened without good identity");
  a_guard_first: assert property (
    req && we && addr == trim_pkg::ADDR_BANDGAP |-> $past(req, 3)
    && $past(addr, 3) == trim_pkg::ADDR_GUARD && $past(wdata, 3) == trim_pkg::GUARD_OPEN_KEY)
    else $error("trim write before guard open");
  a_codes_first: assert property (
    req && we && addr == trim_pkg::ADDR_APPLY
    |-> $past(addr, 3) == trim_pkg::ADDR_BUFFER && $past(addr, 6) == trim_pkg::ADDR_BANDGAP)
    else $error("apply before both codes");
  a_guard_close: assert property (
    req && we && addr == trim_pkg::ADDR_APPLY
    |-> ##3 req && we && addr == trim_pkg::ADDR_GUARD && wdata == trim_pkg::GUARD_CLOSE_KEY)
    else $error("guard not closed after trim");
endmodule

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic        core_clk, rst_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rnd, d;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  bg_out, bf_out, bg_out_b, bf_out_b;
  logic        act, gopen, refused, act_b, gopen_b, refused_b;
  int          bad_count, checks, i;
  integer      mdl [0:255];
  logic [7:0]  amap [6] = '{8'h5e, 8'h60, 8'h74, 8'h78, 8'h7a, 8'h00};

  trim_link_if link();
  trim_link_if link_b();

  // ==========================================================
  // Design ends
  trim_reg_bank trim_reg_bank_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .bandgap_trim_out(bg_out), .buffer_trim_out(bf_out), .trim_active(act),
    .guard_open(gopen), .write_refused(refused));
  trim_host_ctrl trim_host_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  trim_link_asserts trim_link_asserts_inst (.core_clk(core_clk), .rst_n(rst_n),
    .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack));
  // Second device driven directly; code value is arbitrary
  trim_reg_bank #(.ID_CODE(8'h5a)) trim_reg_bank_inst_b (.core_clk(core_clk),
    .rst_n(rst_n), .link(link_b), .bandgap_trim_out(bg_out_b),
    .buffer_trim_out(bf_out_b), .trim_active(act_b), .guard_open(gopen_b),
    .write_refused(refused_b));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task report_and_stop;
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task give_up;
    bad_count++;
    report_and_stop;
  endtask

  task axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) give_up;
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) give_up;
  endtask

  task wait_idle(output logic [31:0] st);
    int n;
    for (n = 0; n < 40; n++) begin
      axi_read(trim_pkg::CSR_STATUS, st, r);
      if (st[trim_pkg::ST_BUSY_BIT] === 1'b0) break;
    end
    if (n == 40) give_up;
  endtask

  task link_xfer(input logic w, input logic [7:0] a, input logic [7:0] v,
                 output logic [7:0] rv, output logic f);
    int n;
    @(posedge core_clk);
    link_b.req <= 1'b1;
    link_b.we <= w;
    link_b.addr <= a;
    link_b.wdata <= v;
    @(posedge core_clk);
    link_b.req <= 1'b0;
    for (n = 0; n < 8; n++) begin
      @(posedge core_clk);
      if (link_b.ack === 1'b1) begin
        rv = link_b.rdata;
        f = refused_b;
        break;
      end
    end
    if (n == 8) give_up;
  endtask

  task dev_read(input logic [7:0] a);
    logic [7:0] rv;
    logic       f;
    link_xfer(1'b0, a, 8'h00, rv, f);
    check("dev_rdata", rv, mdl[a]);
  endtask

  task dev_write(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] rv;
    logic       f;
    logic       prot;
    prot = (a == 8'h74 || a == 8'h78 || a == 8'h7a) && mdl[8'h60] != 1;
    link_xfer(1'b1, a, v, rv, f);
    check("dev_refused", f, prot);
    if (!prot && (a == 8'h60 || a == 8'h78 || a == 8'h7a)) mdl[a] = v;
    if (!prot && a == 8'h74) mdl[a] = v & 8'h01;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    {link_b.req, link_b.we, link_b.addr, link_b.wdata} = '0;
    rst_n = 1'b0;
    rnd = 32'hbfee;
    for (i = 0; i < 256; i++) mdl[i] = 0;
    mdl[8'h5e] = 8'h5a;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check("bg_out", {bf_out, bg_out, 7'h00, act}, 32'h0);
    axi_read(trim_pkg::CSR_STATUS, d, r);
    check("status", d, 32'h0);
    axi_write(trim_pkg::CSR_CTRL, 32'h2, r);
    wait_idle(d);
    check("refused", d[trim_pkg::ST_REFUSED_BIT], 1'b1);
    axi_write(trim_pkg::CSR_CTRL, 32'h1, r);
    wait_idle(d);
    check("id_ok", d[trim_pkg::ST_ID_OK_BIT], 1'b1);
    check("fail", d[trim_pkg::ST_FAIL_BIT], 1'b0);
    check("id", d[15:8], 8'h3c);
    for (i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      axi_write(trim_pkg::CSR_CODES, {16'h0, rnd[15:0]}, r);
      axi_write(trim_pkg::CSR_CTRL, 32'h2, r);
      wait_idle(d);
      repeat (2) @(posedge core_clk);
      #1;
      check("done", d[trim_pkg::ST_DONE_BIT], 1'b1);
      check("bg_out", bg_out, rnd[7:0]);
      check("bf_out", bf_out, rnd[15:8]);
      check("gopen", {act, gopen}, 2'b10);
    end
    axi_write(8'h0c, 32'h0, r);
    check("bresp", r, trim_pkg::RESP_SLVERR);
    axi_read(8'h0c, d, r);
    check("rdata_err", d, 32'h0);
    check("rresp", r, trim_pkg::RESP_SLVERR);
    // Byte-lane write: only the bandgap byte may change
    wstrb <= 4'h1;
    axi_write(trim_pkg::CSR_CODES, 32'h0000c3c3, r);
    wstrb <= 4'hf;
    axi_read(trim_pkg::CSR_CODES, d, r);
    check("codes", d, {16'h0, rnd[15:8], 8'hc3});
    for (i = 0; i < 6; i++) dev_read(amap[i]);
    dev_write(8'h78, 8'ha5);
    dev_write(8'h60, 8'h01);
    check("gopen_b", gopen_b, 1'b1);
    dev_write(8'h78, rnd[23:16]);
    dev_write(8'h7a, rnd[31:24]);
    #1;
    check("bg_out_b", {bf_out_b, bg_out_b}, 16'h0);
    dev_write(8'h74, 8'hff);
    dev_write(8'h5e, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    check("bg_out_b", {bf_out_b, bg_out_b}, rnd[31:16]);
    dev_write(8'h60, 8'h02);
    dev_write(8'h7a, 8'h00);
    dev_write(8'h74, 8'h00);
    for (i = 0; i < 6; i++) dev_read(amap[i]);
    check("bf_out_b", bf_out_b, rnd[31:24]);
    report_and_stop;
  end
endmodule
